// [rtl/cdcfg_map.svh]
/*
  Register offsets, field positions, reset values and code tables of the
  chop and current-detect configuration block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef CDCFG_MAP_SVH
`define CDCFG_MAP_SVH

`define CDCFG_ADDR_W 4
`define CDCFG_OFF_CONFIG 4'h6
`define CDCFG_OFF_THR_HI 4'h7
`define CDCFG_OFF_THR_LO 4'h8
`define CDCFG_OFF_STATUS 4'hC
`define CDCFG_OFF_MASK 4'hD
`define CDCFG_OFF_CHOPCMD 4'hE

`define CDCFG_CONFIG_RST 16'h0600
`define CDCFG_THR_HI_RST 16'h0000
`define CDCFG_THR_LO_RST 8'h00
`define CDCFG_CONFIG_WMASK 16'h1FFF

`define CDCFG_POS_DETECT_ON 0
`define CDCFG_POS_WIN_LO 1
`define CDCFG_POS_WIN_HI 3
`define CDCFG_POS_CNT_LO 4
`define CDCFG_POS_CNT_HI 6
`define CDCFG_POS_ALLCH 7
`define CDCFG_POS_CHOP_ON 8
`define CDCFG_POS_DLY_LO 9
`define CDCFG_POS_DLY_HI 12
`define CDCFG_POS_THR_LO_LO 8
`define CDCFG_POS_THR_LO_HI 15

`define CDCFG_ST_DETECT 0
`define CDCFG_ST_CHOP_DONE 1
`define CDCFG_ST_W 2

`define CDCFG_WIN_128 12'd128
`define CDCFG_WIN_256 12'd256
`define CDCFG_WIN_512 12'd512
`define CDCFG_WIN_768 12'd768
`define CDCFG_WIN_1280 12'd1280
`define CDCFG_WIN_1792 12'd1792
`define CDCFG_WIN_2560 12'd2560
`define CDCFG_WIN_3584 12'd3584

`endif

// [rtl/cdcfg_pkg.sv]
/*
  Types of the chop and current-detect configuration block.
  Assumes cdcfg_map.svh is on the include path.
*/
package cdcfg_pkg;
  `include "cdcfg_map.svh"

  typedef struct packed {
    logic [2:0] reserved;
    logic [3:0] chop_settle_delay;
    logic global_chop_on;
    logic detect_all_channels;
    logic [2:0] detect_exceed_count;
    logic [2:0] detect_window_length;
    logic detect_mode_on;
  } cdcfg_config_t;

  typedef struct packed {
    logic [`CDCFG_ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } cdcfg_bus_t;

  typedef enum logic [2:0] {
    CDCFG_CHOP_IDLE = 3'b001,
    CDCFG_CHOP_SETTLE = 3'b010,
    CDCFG_CHOP_MEASURE = 3'b100
  } cdcfg_chop_t;
endpackage

// [rtl/cdcfg_top.sv]
/*
  Chop and current-detect configuration registers with the chop settling
  timer and the current-detect window counter they steer.
  Assumes a synchronous register port, one conversion-result strobe per
  conversion period and a one-cycle chop strobe from the modulator.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cdcfg_map.svh"

module cdcfg_top #(
  parameter int CHANNELS = 2,
  parameter int RESULT_W = 24
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire cdcfg_pkg::cdcfg_bus_t bus,
  output logic [15:0] rdata,
  input wire logic mod_tick,
  input wire logic chop_strobe,
  input wire logic conv_valid,
  input wire logic [CHANNELS-1:0] chan_enabled,
  input wire logic [CHANNELS*RESULT_W-1:0] conv_result,
  output logic measure_go,
  output logic detect_event,
  output logic irq
);
  import cdcfg_pkg::*;

  cdcfg_config_t cfg;
  logic [15:0] detect_threshold_upper;
  logic [7:0] detect_threshold_low;
  logic [`CDCFG_ST_W-1:0] status;
  logic [`CDCFG_ST_W-1:0] mask;
  cdcfg_chop_t chop_state;
  logic [16:0] settle_cnt;
  logic [11:0] win_cnt;
  logic [7:0] hit_cnt;
  logic [`CDCFG_ST_W-1:0] ev;
  logic [`CDCFG_ST_W-1:0] next_status;
  logic [`CDCFG_ST_W-1:0] next_mask;
  logic [23:0] thr;
  logic any_hit;
  logic all_hit;
  logic counts;

  function automatic logic [11:0] win_len(input logic [2:0] code);
    case (code)
      3'h0: win_len = `CDCFG_WIN_128;
      3'h1: win_len = `CDCFG_WIN_256;
      3'h2: win_len = `CDCFG_WIN_512;
      3'h3: win_len = `CDCFG_WIN_768;
      3'h4: win_len = `CDCFG_WIN_1280;
      3'h5: win_len = `CDCFG_WIN_1792;
      3'h6: win_len = `CDCFG_WIN_2560;
      default: win_len = `CDCFG_WIN_3584;
    endcase
  endfunction

  // 2^(code+1) periods, 2 up to 65536
  function automatic logic [16:0] settle_len(input logic [3:0] code);
    settle_len = 17'h00002 << code;
  endfunction

  function automatic logic [8:0] hits_needed(input logic [2:0] code);
    hits_needed = 9'h001 << code;
  endfunction

  // register writes; reserved bits are held at zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= cdcfg_config_t'(`CDCFG_CONFIG_RST);
      detect_threshold_upper <= `CDCFG_THR_HI_RST;
      detect_threshold_low <= `CDCFG_THR_LO_RST;
      mask <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        `CDCFG_OFF_CONFIG: begin
          cfg <= cdcfg_config_t'(bus.wdata & `CDCFG_CONFIG_WMASK);
        end
        `CDCFG_OFF_THR_HI: begin
          detect_threshold_upper <= bus.wdata;
        end
        `CDCFG_OFF_THR_LO: begin
          detect_threshold_low <=
            bus.wdata[`CDCFG_POS_THR_LO_HI:`CDCFG_POS_THR_LO_LO];
        end
        `CDCFG_OFF_MASK: begin
          mask <= bus.wdata[`CDCFG_ST_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `CDCFG_OFF_CONFIG: rdata <= cfg;
        `CDCFG_OFF_THR_HI: rdata <= detect_threshold_upper;
        `CDCFG_OFF_THR_LO: rdata <= {detect_threshold_low, 8'h00};
        `CDCFG_OFF_STATUS: rdata <= {14'h0000, status};
        `CDCFG_OFF_MASK: rdata <= {14'h0000, mask};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // chop settling: counts modulator ticks after a chop strobe seen in idle with global_chop_on set
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chop_state <= CDCFG_CHOP_IDLE;
      settle_cnt <= '0;
      measure_go <= 1'b0;
    end else begin
      measure_go <= 1'b0;
      case (chop_state)
        CDCFG_CHOP_IDLE: begin
          if (cfg.global_chop_on && chop_strobe) begin
            chop_state <= CDCFG_CHOP_SETTLE;
            settle_cnt <= settle_len(cfg.chop_settle_delay);
          end
        end
        CDCFG_CHOP_SETTLE: begin
          if (!cfg.global_chop_on) begin
            chop_state <= CDCFG_CHOP_IDLE;
          end else if (mod_tick) begin
            if (settle_cnt == 17'h00001) begin
              chop_state <= CDCFG_CHOP_MEASURE;
              measure_go <= 1'b1;
            end
            settle_cnt <= settle_cnt - 17'h00001;
          end
        end
        CDCFG_CHOP_MEASURE: begin
          chop_state <= CDCFG_CHOP_IDLE;
        end
        default: chop_state <= CDCFG_CHOP_IDLE;
      endcase
    end
  end

  // threshold compare on the result of each enabled channel, unsigned magnitude
  assign thr = {detect_threshold_upper, detect_threshold_low};

  always_comb begin
    any_hit = 1'b0;
    all_hit = 1'b1;
    for (int i = 0; i < CHANNELS; i++) begin
      if (chan_enabled[i]) begin
        if (conv_result[i*RESULT_W +: RESULT_W] > thr) begin
          any_hit = 1'b1;
        end else begin
          all_hit = 1'b0;
        end
      end
    end
    if (chan_enabled == '0) begin
      all_hit = 1'b0;
    end
  end

  assign counts = cfg.detect_all_channels ? all_hit : any_hit;

  // window and exceedance counters; one detection per window at most
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt <= '0;
      hit_cnt <= '0;
      detect_event <= 1'b0;
    end else begin
      detect_event <= 1'b0;
      if (!cfg.detect_mode_on) begin
        win_cnt <= '0;
        hit_cnt <= '0;
      end else if (conv_valid) begin
        if (win_cnt == 12'h000) begin
          hit_cnt <= {7'h00, counts};
          if (counts && hits_needed(cfg.detect_exceed_count) == 9'h001) begin
            detect_event <= 1'b1;
          end
        end else if (counts && {1'b0, hit_cnt} <
                     hits_needed(cfg.detect_exceed_count)) begin
          hit_cnt <= hit_cnt + 8'h01;
          if ({1'b0, hit_cnt} + 9'h001 ==
              hits_needed(cfg.detect_exceed_count)) begin
            detect_event <= 1'b1;
          end
        end
        if (win_cnt + 12'h001 >= win_len(cfg.detect_window_length)) begin
          win_cnt <= '0;
        end else begin
          win_cnt <= win_cnt + 12'h001;
        end
      end
    end
  end

  always_comb begin
    ev = '0;
    ev[`CDCFG_ST_DETECT] = detect_event;
    ev[`CDCFG_ST_CHOP_DONE] = measure_go;
  end

  // set wins over a write-one clear
  always_comb begin
    next_status = status | ev;
    if (bus.wr && bus.addr == `CDCFG_OFF_STATUS) begin
      next_status = (status & ~bus.wdata[`CDCFG_ST_W-1:0]) | ev;
    end
    next_mask = mask;
    if (bus.wr && bus.addr == `CDCFG_OFF_MASK) begin
      next_mask = bus.wdata[`CDCFG_ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // built from next values so irq drops with the clear, not a cycle late
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  sequence s_settle_done;
    chop_state == CDCFG_CHOP_SETTLE && mod_tick && cfg.global_chop_on
      && settle_cnt == 17'h00001;
  endsequence

  property p_chop_go;
    @(posedge core_clk) disable iff (!resetn)
      s_settle_done |=> measure_go;
  endproperty
  a_chop_go: assert property (p_chop_go)
    else $error("measure start missing after settling");

  property p_settle_load;
    @(posedge core_clk) disable iff (!resetn)
      (chop_state == CDCFG_CHOP_IDLE && cfg.global_chop_on && chop_strobe)
      |=> settle_cnt == (17'h00002 << $past(cfg.chop_settle_delay));
  endproperty
  a_settle_load: assert property (p_settle_load)
    else $error("settle count loaded wrongly");

  property p_no_go_off;
    @(posedge core_clk) disable iff (!resetn)
      (chop_state == CDCFG_CHOP_IDLE) |=> !measure_go;
  endproperty
  a_no_go_off: assert property (p_no_go_off)
    else $error("measure start without settling");

  property p_allch;
    @(posedge core_clk) disable iff (!resetn)
      (cfg.detect_all_channels && chan_enabled[CHANNELS-1]
        && conv_result[CHANNELS*RESULT_W-1 -: RESULT_W] <= thr) |-> !counts;
  endproperty
  a_allch: assert property (p_allch)
    else $error("partial exceedance counted in all-channel mode");

  property p_detect_off;
    @(posedge core_clk) disable iff (!resetn)
      !cfg.detect_mode_on |=> !detect_event;
  endproperty
  a_detect_off: assert property (p_detect_off)
    else $error("detection while detect mode off");

  property p_win_bound;
    @(posedge core_clk) disable iff (!resetn)
      (cfg.detect_mode_on && conv_valid)
      |=> win_cnt < win_len($past(cfg.detect_window_length));
  endproperty
  a_win_bound: assert property (p_win_bound)
    else $error("window counter beyond window length");

  property p_thr_write;
    @(posedge core_clk) disable iff (!resetn)
      (bus.wr && bus.addr == `CDCFG_OFF_THR_HI)
      |=> detect_threshold_upper == $past(bus.wdata);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("upper threshold not written");

  property p_reserved;
    @(posedge core_clk) disable iff (!resetn)
      cfg.reserved == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved config bits set");

  property p_win_clear;
    @(posedge core_clk) disable iff (!resetn)
      (cfg.detect_mode_on && conv_valid && win_cnt == 12'h000 && !counts)
      |=> hit_cnt == 8'h00;
  endproperty
  a_win_clear: assert property (p_win_clear)
    else $error("hit count not cleared at window start");
endmodule
`default_nettype wire

// [tb/cdcfg_top_tb.sv]
/*
  Self-checking bench for the chop and current-detect configuration block.
  Assumes cdcfg_pkg, cdcfg_map.svh and cdcfg_top are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module cdcfg_top_tb;
  import cdcfg_pkg::*;
  logic core_clk;
  logic resetn;
  cdcfg_bus_t bus;
  logic [15:0] rdata;
  logic mod_tick;
  logic chop_strobe;
  logic conv_valid;
  logic [1:0] chan_enabled;
  logic [47:0] conv_result;
  logic measure_go;
  logic detect_event;
  logic irq;
  int fails = 0;
  int check_count = 0;
  int go_cnt = 0;
  int win_len [8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
  // threshold is 0x000010; equal does not count, compare is strict
  localparam logic [23:0] HIT = 24'h000011;
  localparam logic [23:0] MISS = 24'h000010;

  cdcfg_top dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus(bus),
    .rdata(rdata),
    .mod_tick(mod_tick),
    .chop_strobe(chop_strobe),
    .conv_valid(conv_valid),
    .chan_enabled(chan_enabled),
    .conv_result(conv_result),
    .measure_go(measure_go),
    .detect_event(detect_event),
    .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // catches a settle pulse that comes early
  always @(posedge core_clk) begin
    if (measure_go === 1'b1) go_cnt <= go_cnt + 1;
  end

  task automatic chk_reg(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [15:0] exp);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    chk_reg(what, exp, rdata);
  endtask

  task automatic chop_run(input int code);
    int n;
    int g0;
    n = 2 << code;
    g0 = go_cnt;
    @(posedge core_clk);
    chop_strobe <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      chop_strobe <= 1'b0;
      mod_tick <= 1'b1;
    end
    @(posedge core_clk);
    mod_tick <= 1'b0;
    #1;
    chk_bit("settle done", 1'b1, measure_go);
    chk_reg("early settle", 16'(g0), 16'(go_cnt));
  endtask

  task automatic conv(input logic [23:0] r0, input logic [23:0] r1,
                      input logic exp);
    @(posedge core_clk);
    conv_valid <= 1'b1;
    conv_result <= {r1, r0};
    @(posedge core_clk);
    conv_valid <= 1'b0;
    #1;
    chk_bit("detect", exp, detect_event);
  endtask

  // a hit left over from the old window must not carry into the next
  task automatic window_run(input int w);
    wr(4'h6, 16'h0000);
    wr(4'h6, 16'h0011 | 16'(w << 1));
    conv(HIT, MISS, 1'b0);
    for (int i = 1; i < win_len[w]; i++) conv(MISS, MISS, 1'b0);
    conv(HIT, MISS, 1'b0);
    conv(MISS, HIT, 1'b1);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    give_verdict;
  end

  initial begin
    resetn = 1'b0;
    bus = '0;
    mod_tick = 1'b0;
    chop_strobe = 1'b0;
    conv_valid = 1'b0;
    chan_enabled = 2'b11;
    conv_result = '0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rd_chk("config reset", 4'h6, 16'h0600);
    rd_chk("thr high reset", 4'h7, 16'h0000);
    rd_chk("thr low reset", 4'h8, 16'h0000);
    wr(4'hE, 16'hFFFF);
    rd_chk("unmapped read", 4'hE, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rd_chk("config reserved", 4'h6, 16'h1FFF);
    wr(4'h7, 16'hA5C3);
    rd_chk("thr high rw", 4'h7, 16'hA5C3);
    wr(4'h8, 16'h5AFF);
    rd_chk("thr low byte", 4'h8, 16'h5A00);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      wr(4'h6, 16'h0100 | 16'(c << 9));
      chop_run(c);
    end
    rd_chk("chop status", 4'hC, 16'h0002);
    chk_bit("irq masked", 1'b0, irq);
    wr(4'hD, 16'h0002);
    rd_chk("mask", 4'hD, 16'h0002);
    chk_bit("irq unmasked", 1'b1, irq);
    wr(4'hC, 16'h0002);
    rd_chk("status cleared", 4'hC, 16'h0000);
    chk_bit("irq cleared", 1'b0, irq);
    $display("test chop done");
    wr(4'h7, 16'h0000);
    wr(4'h8, 16'h1000);
    for (int k = 0; k < 8; k++) begin
      wr(4'h6, 16'h0000);
      wr(4'h6, 16'h000F | 16'(k << 4));
      for (int i = 1; i < (1 << k); i++) conv(HIT, HIT, 1'b0);
      conv(HIT, HIT, 1'b1);
    end
    wr(4'hD, 16'h0001);
    rd_chk("detect status", 4'hC, 16'h0001);
    chk_bit("irq detect", 1'b1, irq);
    wr(4'hC, 16'h0001);
    rd_chk("detect cleared", 4'hC, 16'h0000);
    wr(4'h6, 16'h0000);
    wr(4'h6, 16'h0081);
    conv(HIT, MISS, 1'b0);
    conv(HIT, HIT, 1'b1);
    wr(4'h6, 16'h0000);
    chan_enabled <= 2'b01;
    wr(4'h6, 16'h0081);
    conv(HIT, MISS, 1'b1);
    @(posedge core_clk);
    chan_enabled <= 2'b11;
    $display("test detect done");
    for (int w = 0; w < 8; w++) window_run(w);
    $display("test windows done");
    give_verdict;
  end
endmodule
`default_nettype wire
